// ==== rtl/pmi_pkg.sv ====
// Purpose: Shared constants and types for the power-good interrupt register slice
// Assumes: Serial link pins are sampled synchronously to mclk_in
// Notes:   Offsets are register addresses on the serial link, not byte addresses
package pmi_pkg;

    // Serial frame layout
    localparam int unsigned CMD_W       = 2;      // Command bits at frame start
    localparam int unsigned ADDR_W      = 5;      // Register address field width
    localparam int unsigned DATA_W      = 8;      // Register data width
    localparam logic [3:0]  HDR_BITS    = 4'h7;   // Command plus address bits
    localparam logic [3:0]  FRAME_BITS  = 4'hF;   // Command, address and data bits
    localparam logic [1:0]  CMD_WRITE   = 2'h2;   // Write command code
    localparam logic [1:0]  CMD_READ    = 2'h3;   // Read command code

    // Register addresses
    localparam logic [4:0]  ADDR_IRQ_EN = 5'h0C;  // interrupt_enable
    localparam logic [4:0]  ADDR_STATUS = 5'h0D;  // power_good_status
    localparam logic [4:0]  ADDR_MISC   = 5'h0E;  // misc_control

    // Field positions
    localparam int unsigned COMP_BIT    = 0;      // Comparator bit in enable and status
    localparam int unsigned BUCK_LSB    = 1;      // Regulator one bit
    localparam int unsigned BUCK_MSB    = 3;      // Regulator three bit
    localparam int unsigned POL_BIT     = 0;      // Polarity bit of misc_control

    // Reset values
    localparam logic [3:0]  IRQ_EN_RST  = 4'h1;   // Comparator enabled, regulators off
    localparam logic        POL_RST     = 1'h0;   // Active-low interrupt
    localparam logic        IRQ_RST     = 1'h1;   // Inactive level for active-low

    // Voltage code map for regulators one and two
    localparam int unsigned VCODE_W     = 6;      // Voltage code width
    localparam int unsigned MV_W        = 12;     // Target width in millivolts
    localparam logic [5:0]  VCODE_MAX   = 6'h32;  // Highest distinct code
    localparam logic [11:0] VBASE_MV    = 12'h44C; // 1100 mV at code 0
    localparam logic [11:0] VSTEP_MV    = 12'h032; // 50 mV per step

    // Frame sequencer states
    typedef enum logic [1:0] {
        PMI_IDLE = 2'b00,   // Chip select inactive
        PMI_HDR  = 2'b01,   // Receiving command and address
        PMI_DATA = 2'b10,   // Receiving or sending data byte
        PMI_DONE = 2'b11    // Frame complete, extra clocks ignored
    } pmi_state_t;

endpackage : pmi_pkg

// ==== rtl/pmi_vcode_dec.sv ====
// Purpose: Turn a 6-bit regulator voltage code into a target in millivolts
// Assumes: Code comes from a register outside this slice
// Notes:   Output is registered, one cycle behind the code
module pmi_vcode_dec
    import pmi_pkg::*;
(
    input  wire logic                mclk_in,     // Core clock
    input  wire logic                rst_in,      // Synchronous reset, active high
    input  wire logic [VCODE_W-1:0]  code_in,     // Voltage code
    output logic      [MV_W-1:0]     target_mv_out // Target voltage in mV
);

    logic [MV_W-1:0] target_r;   // Registered target
    logic [MV_W-1:0] target_nxt; // Next target
    logic [5:0]      steps;      // Clamped step count

    // Linear map with saturation at the top code
    always_comb begin
        steps = code_in;
        if (code_in > VCODE_MAX) begin
            steps = VCODE_MAX;
        end
        target_nxt = MV_W'(VBASE_MV + VSTEP_MV * {6'h00, steps});
    end

    // Output register
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            target_r <= VBASE_MV;
        end else begin
            target_r <= target_nxt;
        end
    end

    assign target_mv_out = target_r;

endmodule : pmi_vcode_dec

// ==== rtl/pmi_regs.sv ====
// Purpose: Interrupt enable, power-good status and polarity registers on a serial link
// Assumes: Link pins are synchronous to mclk_in; link clock idles low, data sampled on rise
// Notes:   Frame is 2 command bits, 5 address bits, 8 data bits, MSB first

// How it works
// - Enable bit 0 gates comparator, reset one
// - Status bits 3..1 show regulator power-good
// - Status bit 0 shows live comparator level
// - Misc bit 0 picks interrupt polarity, reset low
// - Code 0 is 1.10 V, 50 mV steps
// - Codes above 0x32 saturate at 3.60 V
module pmi_regs
    import pmi_pkg::*;
(
    input  wire logic                 mclk_in,           // Core clock
    input  wire logic                 rst_in,            // Synchronous reset, active high
    input  wire logic                 spi_sclk_in,       // Link clock, sampled as data
    input  wire logic                 spi_cs_n_in,       // Link select, active low
    input  wire logic                 spi_mosi_in,       // Link data from host
    output logic                      spi_miso_out,      // Link data to host
    output logic                      spi_miso_oe_out,   // High while driving link data
    input  wire logic [3:1]           buck_pgood_in,     // Regulator above 90% of target
    input  wire logic                 comp_in,           // Supply comparator output
    input  wire logic [VCODE_W-1:0]   buck1_code_in,     // Regulator one voltage code
    input  wire logic [VCODE_W-1:0]   buck2_code_in,     // Regulator two voltage code
    output logic      [MV_W-1:0]      buck1_target_mv_out, // Regulator one target mV
    output logic      [MV_W-1:0]      buck2_target_mv_out, // Regulator two target mV
    output logic                      irq_out            // Interrupt, polarity selectable
);

    // Frame sequencer state
    pmi_state_t         state_r;      // Current frame phase
    pmi_state_t         state_nxt;    // Next frame phase
    logic [3:0]         cnt_r;        // Bits received in frame
    logic [3:0]         cnt_nxt;      // Next bit count
    logic [6:0]         hdr_r;        // Command and address shift register
    logic [6:0]         hdr_nxt;      // Next header
    logic [7:0]         rx_r;         // Incoming data shift register
    logic [7:0]         rx_nxt;       // Next incoming data
    logic [7:0]         tx_r;         // Outgoing data shift register
    logic [7:0]         tx_nxt;       // Next outgoing data
    logic               miso_r;       // Registered link output bit
    logic               miso_nxt;     // Next link output bit
    logic               sclk_q_r;     // Previous link clock sample
    logic               sclk_q_nxt;   // Next link clock sample

    // Register state
    logic [3:0]         ien_r;        // interrupt_enable bits 3..0
    logic [3:0]         ien_nxt;      // Next enable bits
    logic               pol_r;        // misc_control polarity bit
    logic               pol_nxt;      // Next polarity
    logic               irq_r;        // Registered interrupt pin
    logic               irq_nxt;      // Next interrupt pin

    // Decode helpers
    logic               sclk_rise;    // Link clock rising edge seen
    logic               sclk_fall;    // Link clock falling edge seen
    logic [1:0]         cmd;          // Command bits of header
    logic [4:0]         addr;         // Address bits of header
    logic [4:0]         addr_live;    // Address once last header bit arrives
    logic [1:0]         cmd_live;     // Command once last header bit arrives
    logic [3:0]         status;       // Live status bits 3..0
    logic               pending;      // Any enabled condition present
    logic [7:0]         wdata;        // Write data once last bit arrives

    // Status word assembly from live inputs
    always_comb begin
        status          = '0;
        status[BUCK_MSB:BUCK_LSB] = buck_pgood_in;
        status[COMP_BIT] = comp_in;
    end

    // Read mux; reserved bits and foreign addresses read zero
    function automatic logic [7:0] reg_read(input logic [4:0] a,
                                            input logic [3:0] en,
                                            input logic [3:0] st,
                                            input logic       pl);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            ADDR_IRQ_EN: d = {4'h0, en};
            ADDR_STATUS: d = {4'h0, st};
            ADDR_MISC:   d = {7'h00, pl};
            default:     d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    // Edge detection and header fields
    always_comb begin
        sclk_q_nxt = spi_sclk_in;
        sclk_rise  = spi_sclk_in & ~sclk_q_r;
        sclk_fall  = ~spi_sclk_in & sclk_q_r;
        cmd        = hdr_r[6:5];
        addr       = hdr_r[4:0];
        cmd_live   = hdr_r[5:4];
        addr_live  = {hdr_r[3:0], spi_mosi_in};
        wdata      = {rx_r[6:0], spi_mosi_in};
    end

    // Frame sequencer next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        hdr_nxt   = hdr_r;
        rx_nxt    = rx_r;
        tx_nxt    = tx_r;
        miso_nxt  = miso_r;
        if (spi_cs_n_in) begin
            // Deselect aborts any frame
            state_nxt = PMI_IDLE;
            cnt_nxt   = 4'h0;
            tx_nxt    = 8'h00;
            miso_nxt  = 1'b0;
        end else begin
            case (state_r)
                PMI_IDLE: begin
                    state_nxt = PMI_HDR;
                    cnt_nxt   = 4'h0;
                    // A rise coinciding with select counts as bit one
                    if (sclk_rise) begin
                        hdr_nxt = {hdr_r[5:0], spi_mosi_in};
                        cnt_nxt = 4'h1;
                    end
                end
                PMI_HDR: begin
                    if (sclk_rise) begin
                        hdr_nxt = {hdr_r[5:0], spi_mosi_in};
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r + 4'h1 == HDR_BITS) begin
                            state_nxt = PMI_DATA;
                            // Snapshot read data; writes return zeros
                            if (cmd_live == CMD_READ) begin
                                tx_nxt = reg_read(addr_live, ien_r, status, pol_r);
                            end else begin
                                tx_nxt = 8'h00;
                            end
                        end
                    end
                end
                PMI_DATA: begin
                    if (sclk_fall) begin
                        // Present next data bit for the host's next rise
                        miso_nxt = tx_r[7];
                        tx_nxt   = {tx_r[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        rx_nxt  = wdata;
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r + 4'h1 == FRAME_BITS) begin
                            state_nxt = PMI_DONE;
                        end
                    end
                end
                PMI_DONE: begin
                    // Surplus clocks are ignored until deselect
                    if (sclk_fall) begin
                        miso_nxt = 1'b0;
                    end
                end
                default: begin
                    state_nxt = PMI_IDLE;
                end
            endcase
        end
    end

    // Register writes and interrupt pin
    always_comb begin
        ien_nxt = ien_r;
        pol_nxt = pol_r;
        if (!spi_cs_n_in && state_r == PMI_DATA && sclk_rise
            && cnt_r + 4'h1 == FRAME_BITS && cmd == CMD_WRITE) begin
            case (addr)
                ADDR_IRQ_EN: ien_nxt = wdata[BUCK_MSB:COMP_BIT];
                ADDR_MISC:   pol_nxt = wdata[POL_BIT];
                default:     ien_nxt = ien_r;                     // Status is read-only
            endcase
        end
        pending = |(ien_r & status);
        irq_nxt = pol_r ? pending : ~pending;
    end

    // State registers
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_r  <= PMI_IDLE;
            cnt_r    <= 4'h0;
            hdr_r    <= 7'h00;
            rx_r     <= 8'h00;
            tx_r     <= 8'h00;
            miso_r   <= 1'b0;
            sclk_q_r <= 1'b0;
            ien_r    <= IRQ_EN_RST;
            pol_r    <= POL_RST;
            irq_r    <= IRQ_RST;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            hdr_r    <= hdr_nxt;
            rx_r     <= rx_nxt;
            tx_r     <= tx_nxt;
            miso_r   <= miso_nxt;
            sclk_q_r <= sclk_q_nxt;
            ien_r    <= ien_nxt;
            pol_r    <= pol_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // Link output drives only while selected
    assign spi_miso_out    = miso_r;
    assign spi_miso_oe_out = ~spi_cs_n_in;
    assign irq_out         = irq_r;

    // Voltage code to target conversion for regulators one and two
    pmi_vcode_dec u_dec1 (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .code_in       (buck1_code_in),
        .target_mv_out (buck1_target_mv_out)
    );

    pmi_vcode_dec u_dec2 (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .code_in       (buck2_code_in),
        .target_mv_out (buck2_target_mv_out)
    );

endmodule : pmi_regs

// ==== test/pmi_regs_assertions.sv ====
// Purpose: Port checks for the power-good register slice
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to pmi_regs from the bench top file
module pmi_regs_assertions
    import pmi_pkg::*;
(
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    input  wire logic               spi_sclk_in,
    input  wire logic               spi_cs_n_in,
    input  wire logic               spi_miso_out,
    input  wire logic               spi_miso_oe_out,
    input  wire logic [3:1]         buck_pgood_in,
    input  wire logic               comp_in,
    input  wire logic [VCODE_W-1:0] buck1_code_in,
    input  wire logic [VCODE_W-1:0] buck2_code_in,
    input  wire logic [MV_W-1:0]    buck1_target_mv_out,
    input  wire logic [MV_W-1:0]    buck2_target_mv_out,
    input  wire logic               irq_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // Target in mV, codes above the top code give the top code's value
    function automatic logic [MV_W-1:0] mv_of(input logic [VCODE_W-1:0] c);
        return VBASE_MV + VSTEP_MV * {6'h00, ((c > VCODE_MAX) ? VCODE_MAX : c)};
    endfunction : mv_of

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    AST_RST_IRQ: assert property (disable iff (1'b0) rst_in |=> irq_out == IRQ_RST)
        else $error("interrupt not inactive in reset");
    AST_RST_TGT: assert property (
        disable iff (1'b0) rst_in |=> buck1_target_mv_out == VBASE_MV
        && buck2_target_mv_out == VBASE_MV)
        else $error("target not at base in reset");
    AST_TGT1: assert property (
        !rst_in |=> buck1_target_mv_out == mv_of($past(buck1_code_in)))
        else $error("regulator one target wrong");
    AST_TGT2: assert property (
        !rst_in |=> buck2_target_mv_out == mv_of($past(buck2_code_in)))
        else $error("regulator two target wrong");
    AST_OE: assert property (spi_miso_oe_out == !spi_cs_n_in)
        else $error("data enable does not follow select");
    AST_MISO_IDLE: assert property (spi_cs_n_in && $past(spi_cs_n_in) |-> !spi_miso_out)
        else $error("data line busy outside frame");
    AST_MISO_STEP: assert property (
        $changed(spi_miso_out) && !spi_cs_n_in && !$past(spi_cs_n_in)
        |-> !$past(spi_sclk_in) && $past(spi_sclk_in, 2))
        else $error("data moved without a link clock fall");
    AST_IRQ_STABLE: assert property (
        spi_cs_n_in [*3] ##0 $stable(comp_in) && $stable(buck_pgood_in)
        |=> $stable(irq_out))
        else $error("interrupt moved with quiet inputs");
endmodule : pmi_regs_assertions

// ==== test/pmi_host_model.sv ====
// Purpose: Host side of the serial register link
// Assumes: Link clock high and low two core clocks each
// Notes:   Data line is inverted when the frame ends
module pmi_host_model
    import pmi_pkg::*;
(
    input  wire logic mclk_in,      // Core clock for pacing
    input  wire logic spi_miso_in,  // Data from device
    output logic      spi_sclk_out, // Link clock, idles low
    output logic      spi_cs_n_out, // Select, active low
    output logic      spi_mosi_out  // Data to device
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle link at time zero
    initial begin
        spi_sclk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_mosi_out = 1'b0;
    end

    // One frame, MSB first; read bits taken just before each rise
    task automatic xfer(input logic [1:0] cmd, input logic [4:0] adr,
                        input logic [7:0] wd, output logic [7:0] rd);
        logic [14:0] frm;
        frm = {cmd, adr, wd};
        rd  = 8'h00;
        @(posedge mclk_in);
        #1;
        spi_cs_n_out = 1'b0;
        for (int i = 0; i < 15; i++) begin
            spi_sclk_out = 1'b0;
            spi_mosi_out = frm[14-i];
            repeat (2) @(posedge mclk_in);
            #1;
            if (i >= 7) rd[14-i] = spi_miso_in;
            spi_sclk_out = 1'b1;
            repeat (2) @(posedge mclk_in);
            #1;
        end
        spi_sclk_out = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
        spi_cs_n_out = 1'b1;
        spi_mosi_out = ~spi_mosi_out;
        // Return off the edge so callers never drive inputs in an edge time step
        repeat (3) @(posedge mclk_in);
        #1;
    endtask : xfer
endmodule : pmi_host_model

// ==== test/pmi_regs_tb.sv ====
// Purpose: Self-checking bench for the power-good register slice
// Assumes: Host model paces the link at four core clocks per bit
// Notes:   Checker is bound at the foot of this file
module pmi_regs_tb
    import pmi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk_in = 1'b0;            // Core clock
    logic        rst_in  = 1'b1;            // Reset, active high
    logic        sclk, cs_n, mosi, miso, oe; // Link wires
    logic        comp, irq;                 // Comparator and interrupt
    logic [3:1]  pgood;                     // Regulator power-good
    logic [5:0]  code1, code2;              // Voltage codes
    logic [11:0] mv1, mv2;                  // Targets
    logic [7:0]  rd;                        // Read data
    int          n_fail = 0;
    int          n_compared = 0;

    always #2 mclk_in = ~mclk_in;

    pmi_regs i_pmi_regs (.mclk_in(mclk_in), .rst_in(rst_in), .spi_sclk_in(sclk),
        .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe),
        .buck_pgood_in(pgood), .comp_in(comp), .buck1_code_in(code1), .buck2_code_in(code2),
        .buck1_target_mv_out(mv1), .buck2_target_mv_out(mv2), .irq_out(irq));
    pmi_host_model i_pmi_host_model (.mclk_in(mclk_in), .spi_miso_in(miso),
        .spi_sclk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi));

    // Compare and count
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Read a register and compare
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        i_pmi_host_model.xfer(CMD_READ, a, 8'hA5, rd);
        chk({4'h0, rd}, {4'h0, e});
    endtask : rdc
    // Wait n edges, then step off the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : cyc
    // Expected target, saturating above the top code
    function automatic logic [11:0] mv(input logic [5:0] c);
        return 12'h44C + 12'h032 * ((c > 6'h32) ? 12'h032 : {6'h00, c});
    endfunction : mv
    task automatic finish_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_fail++;
        finish_test();
    end

    initial begin
        {pgood, comp} = 4'h0;
        code1 = 6'h00;
        code2 = 6'h00;
        cyc(20);
        rst_in = 1'b0;
        cyc(2);
        chk({11'h000, irq}, 12'h001);
        rdc(ADDR_IRQ_EN, 8'h01);
        rdc(ADDR_MISC, 8'h00);
        rdc(5'h1F, 8'h00);
        for (int i = 0; i < 16; i += 5) begin
            {pgood, comp} = 4'(i);
            cyc(2);
            rdc(ADDR_STATUS, {4'h0, 4'(i)});
        end
        chk({11'h000, irq}, 12'h000);
        i_pmi_host_model.xfer(CMD_WRITE, ADDR_STATUS, 8'hF0, rd);
        rdc(ADDR_STATUS, 8'h0F);
        i_pmi_host_model.xfer(CMD_WRITE, ADDR_IRQ_EN, 8'hFE, rd);
        rdc(ADDR_IRQ_EN, 8'h0E);
        {pgood, comp} = 4'h1;
        cyc(2);
        chk({11'h000, irq}, 12'h001);
        {pgood, comp} = 4'h4;
        cyc(2);
        chk({11'h000, irq}, 12'h000);
        i_pmi_host_model.xfer(CMD_WRITE, ADDR_MISC, 8'hFF, rd);
        rdc(ADDR_MISC, 8'h01);
        chk({11'h000, irq}, 12'h001);
        pgood = 3'h0;
        cyc(2);
        chk({11'h000, irq}, 12'h000);
        for (int c = 0; c < 64; c++) begin
            code1 = 6'(c);
            code2 = ~6'(c);
            cyc(2);
            chk(mv1, mv(code1));
            chk(mv2, mv(code2));
        end
        rst_in = 1'b1;
        cyc(2);
        rst_in = 1'b0;
        cyc(2);
        chk({11'h000, irq}, 12'h001);
        rdc(ADDR_MISC, 8'h00);
        rdc(ADDR_IRQ_EN, 8'h01);
        finish_test();
    end
endmodule : pmi_regs_tb

bind pmi_regs pmi_regs_assertions i_pmi_regs_assertions (.mclk_in(mclk_in), .rst_in(rst_in),
    .spi_sclk_in(spi_sclk_in), .spi_cs_n_in(spi_cs_n_in), .spi_miso_out(spi_miso_out),
    .spi_miso_oe_out(spi_miso_oe_out), .buck_pgood_in(buck_pgood_in), .comp_in(comp_in),
    .buck1_code_in(buck1_code_in), .buck2_code_in(buck2_code_in),
    .buck1_target_mv_out(buck1_target_mv_out), .buck2_target_mv_out(buck2_target_mv_out),
    .irq_out(irq_out));
